// file: vim_membership.sv
// vlan classification, ingress filter and membership tables with apb registers
// assumes frame descriptors come from logic on pclk; apb master on pclk
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module vim_membership #(
	parameter int NP = 8,
	parameter int NE = 8,
	localparam int PW = (NP > 1) ? $clog2(NP) : 1,
	localparam int EW = (NE > 1) ? $clog2(NE) : 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_valid,
	input wire logic [PW-1:0] rx_port,
	input wire logic rx_tagged,
	input wire logic [11:0] rx_vid,
	output logic fwd_valid,
	output logic fwd_accept,
	output logic [11:0] fwd_vid,
	output logic [NP-1:0] fwd_member,
	output logic [NP-1:0] fwd_tag
);

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [1:0] mode_next;
		logic [1:0] mode_cur;
		logic [NP-1:0] ing_en;
		logic [NP-1:0] trunk_mask;
		logic [PW-1:0] anchor;
		logic [EW-1:0] ent_sel;
		logic [4:0] pb_view;
		logic [NE-1:0][11:0] ent_vid;
		logic [NE-1:0][NP-1:0] ent_egr;
		logic [NE-1:0][NP-1:0] ent_fbd;
		logic [NE-1:0][NP-1:0] ent_tag;
		logic [NE-1:0][31:0] ent_name;
		logic [NP-1:0][11:0] pdv;
		logic [NP-1:0][4:0] pb_vid;
		logic fwd_valid;
		logic fwd_accept;
		logic [11:0] fwd_vid;
		logic [NP-1:0] fwd_member;
		logic [NP-1:0] fwd_tag;
	} vim_state_t;

	vim_state_t s_ff;
	vim_state_t nxt_s;

	// trunk anchor resolution
	function automatic logic [PW-1:0] eff_port(input logic [NP-1:0] tm,
		input logic [PW-1:0] anc, input logic [PW-1:0] p);
		eff_port = tm[p] ? anc : p;
	endfunction

	// vid write outside 1 to 4094, upper bits included
	function automatic logic vid_bad(input logic [31:0] d);
		vid_bad = (d[11:0] == 12'h000) || (d > 32'(vim_pkg::VID_MAX));
	endfunction

	// members and tagging ports of a vid in the static table
	function automatic logic [2*NP-1:0] tbl_lookup(input vim_state_t st, input logic [11:0] vid);
		logic [NP-1:0] m;
		logic [NP-1:0] t;
		m = '0;
		t = '0;
		for (int e = 0; e < NE; e++) begin
			if (st.ent_vid[e] == vid && vid != 12'h000) begin
				m = m | (st.ent_egr[e] & ~st.ent_fbd[e]);
				t = t | st.ent_tag[e];
			end
		end
		tbl_lookup = {t & m, m};
	endfunction

	localparam logic [1:0] OFF_WIN_PDV_T = vim_pkg::OFF_WIN_PDV;
	localparam logic [1:0] OFF_WIN_PB_T = vim_pkg::OFF_WIN_PB;

	logic acc;
	logic [3:0] idx;
	logic idx_ok;
	logic [31:0] rd;
	logic err;
	logic [NP-1:0] ing_eff;
	logic [NP-1:0] pb_mem;
	logic [NP-1:0] pb_oth;
	logic [PW-1:0] rx_eff;
	logic [11:0] pv;
	logic [11:0] cvid;
	logic [2*NP-1:0] lk;
	logic [NP-1:0] mem;
	logic [11:0] wvid;

	always_comb begin
		nxt_s = s_ff;
		acc = psel && penable;
		idx = paddr[5:2];
		idx_ok = ({28'h0000000, idx} < NP);
		wvid = pwdata[11:0];
		for (int p = 0; p < NP; p++) begin
			ing_eff[p] = s_ff.ing_en[eff_port(s_ff.trunk_mask, s_ff.anchor, PW'(p))];
		end
		for (int p = 0; p < NP; p++) begin
			pb_mem[p] = (s_ff.pb_vid[p] == s_ff.pb_view);
			pb_oth[p] = !pb_mem[p];
		end
		rd = 32'h00000000;
		err = 1'b0;
		if (paddr[7:6] == OFF_WIN_PDV_T) begin
			err = !idx_ok;
			if (idx_ok) begin
				rd = {20'h00000, s_ff.pdv[eff_port(s_ff.trunk_mask, s_ff.anchor, idx[PW-1:0])]};
			end
			if (pwrite && idx_ok && vid_bad(pwdata)) begin
				err = 1'b1;
			end
		end else if (paddr[7:6] == OFF_WIN_PB_T) begin
			err = !idx_ok;
			if (idx_ok) begin
				rd = {27'h0000000, s_ff.pb_vid[idx[PW-1:0]]};
			end
			if (pwrite && pwdata > 32'(vim_pkg::PB_VID_MAX)) begin
				err = 1'b1;
			end
		end else begin
			case (paddr)
				vim_pkg::OFF_CTRL: rd = {30'h00000000, s_ff.mode_next};
				vim_pkg::OFF_STATUS: rd = {28'h0000000, s_ff.mode_cur, s_ff.mode_next};
				vim_pkg::OFF_ING_EN: rd = 32'(ing_eff);
				vim_pkg::OFF_TRUNK: rd = 32'(s_ff.trunk_mask) | (32'(s_ff.anchor) << vim_pkg::TRUNK_ANCHOR_LSB);
				vim_pkg::OFF_ENT_SEL: begin
					rd = 32'(s_ff.ent_sel);
					err = pwrite && ({1'b0, pwdata} >= 33'(NE));
				end
				vim_pkg::OFF_PB_VIEW: rd = 32'(pb_mem) | (32'(pb_oth) << vim_pkg::PB_VIEW_OTHER_LSB);
				vim_pkg::OFF_ENT_VID: begin
					rd = {20'h00000, s_ff.ent_vid[s_ff.ent_sel]};
					err = pwrite && vid_bad(pwdata);
				end
				vim_pkg::OFF_ENT_EGR: rd = 32'(s_ff.ent_egr[s_ff.ent_sel]);
				vim_pkg::OFF_ENT_FBD: rd = 32'(s_ff.ent_fbd[s_ff.ent_sel]);
				vim_pkg::OFF_ENT_TAG: rd = 32'(s_ff.ent_tag[s_ff.ent_sel]);
				vim_pkg::OFF_ENT_NAME: rd = s_ff.ent_name[s_ff.ent_sel];
				vim_pkg::OFF_ENT_CMD: rd = 32'h00000000;
				default: err = 1'b1;
			endcase
		end

		// apb: answer in second access cycle, write on that edge
		if (acc && !s_ff.pready) begin
			nxt_s.pready = 1'b1;
			nxt_s.pslverr = err;
			nxt_s.prdata = pwrite ? 32'h00000000 : rd;
		end else if (s_ff.pready) begin
			nxt_s.pready = 1'b0;
			nxt_s.pslverr = 1'b0;
			if (pwrite && !s_ff.pslverr) begin
				if (paddr[7:6] == OFF_WIN_PDV_T) begin
					// one default vlan; read-only for trunk members other than the anchor
					if (!s_ff.trunk_mask[idx[PW-1:0]]) begin
						nxt_s.pdv[idx[PW-1:0]] = wvid;
					end
				end else if (paddr[7:6] == OFF_WIN_PB_T) begin
					// single owner, zero returns to vlan 1
					nxt_s.pb_vid[idx[PW-1:0]] = (pwdata[4:0] == 5'h00) ? vim_pkg::PB_VID_DEF
						: pwdata[4:0];
				end else begin
					case (paddr)
						vim_pkg::OFF_CTRL: begin
							nxt_s.mode_next = pwdata[1:0];
							if (pwdata[vim_pkg::CTRL_RESTART_BIT]) begin
								nxt_s.mode_cur = pwdata[1:0];
								if (pwdata[1:0] == vim_pkg::MODE_PORT || pwdata[1:0] == vim_pkg::MODE_TAG) begin
									for (int p = 0; p < NP; p++) begin
										nxt_s.pdv[p] = vim_pkg::VID_DEF;
										nxt_s.pb_vid[p] = vim_pkg::PB_VID_DEF;
									end
									nxt_s.ent_vid = '0;
									nxt_s.ent_egr = '0;
									nxt_s.ent_fbd = '0;
									nxt_s.ent_tag = '0;
									nxt_s.ent_name = '0;
									nxt_s.ent_vid[0] = vim_pkg::VID_DEF;
									nxt_s.ent_egr[0] = '1;
								end
							end
						end
						vim_pkg::OFF_ING_EN: begin
							nxt_s.ing_en = (s_ff.ing_en & s_ff.trunk_mask) | (pwdata[NP-1:0] & ~s_ff.trunk_mask);
						end
						vim_pkg::OFF_TRUNK: begin
							nxt_s.trunk_mask = pwdata[NP-1:0];
							nxt_s.anchor = pwdata[vim_pkg::TRUNK_ANCHOR_LSB +: PW];
							nxt_s.trunk_mask[pwdata[vim_pkg::TRUNK_ANCHOR_LSB +: PW]] = 1'b0;
						end
						vim_pkg::OFF_ENT_SEL: nxt_s.ent_sel = pwdata[EW-1:0];
						vim_pkg::OFF_PB_VIEW: nxt_s.pb_view = pwdata[4:0];
						vim_pkg::OFF_ENT_VID: nxt_s.ent_vid[s_ff.ent_sel] = wvid;
						vim_pkg::OFF_ENT_EGR: begin
							nxt_s.ent_egr[s_ff.ent_sel] = pwdata[NP-1:0];
							nxt_s.ent_fbd[s_ff.ent_sel] = s_ff.ent_fbd[s_ff.ent_sel] & ~pwdata[NP-1:0];
						end
						vim_pkg::OFF_ENT_FBD: begin
							nxt_s.ent_fbd[s_ff.ent_sel] = pwdata[NP-1:0];
							nxt_s.ent_egr[s_ff.ent_sel] = s_ff.ent_egr[s_ff.ent_sel] & ~pwdata[NP-1:0];
						end
						vim_pkg::OFF_ENT_TAG: nxt_s.ent_tag[s_ff.ent_sel] = pwdata[NP-1:0];
						vim_pkg::OFF_ENT_NAME: nxt_s.ent_name[s_ff.ent_sel] = pwdata;
						vim_pkg::OFF_ENT_CMD: begin
							if (pwdata[vim_pkg::ENT_CMD_CLEAR_BIT]) begin
								nxt_s.ent_name[s_ff.ent_sel] = 32'h00000000;
								nxt_s.ent_egr[s_ff.ent_sel] = '0;
								nxt_s.ent_fbd[s_ff.ent_sel] = '0;
							end
						end
						default: nxt_s.pb_view = s_ff.pb_view;
					endcase
				end
			end
		end

		// frame classification, one cycle latency
		rx_eff = eff_port(s_ff.trunk_mask, s_ff.anchor, rx_port);
		pv = (s_ff.mode_cur == vim_pkg::MODE_PORT) ? {7'h00, s_ff.pb_vid[rx_eff]}
			: s_ff.pdv[rx_eff];
		cvid = rx_tagged ? rx_vid : pv;
		lk = tbl_lookup(s_ff, cvid);
		for (int p = 0; p < NP; p++) begin
			mem[p] = ({7'h00, s_ff.pb_vid[p]} == cvid);
		end
		nxt_s.fwd_valid = rx_valid;
		case (s_ff.mode_cur)
			vim_pkg::MODE_TAG: begin
				nxt_s.fwd_vid = cvid;
				nxt_s.fwd_member = lk[NP-1:0];
				nxt_s.fwd_tag = lk[2*NP-1:NP];
				nxt_s.fwd_accept = !ing_eff[rx_port] || (rx_tagged && lk[rx_port]);
			end
			vim_pkg::MODE_PORT: begin
				nxt_s.fwd_vid = cvid;
				nxt_s.fwd_member = mem;
				nxt_s.fwd_tag = '0;
				nxt_s.fwd_accept = !ing_eff[rx_port] || (rx_tagged && mem[rx_port]);
			end
			default: begin
				nxt_s.fwd_vid = vim_pkg::VID_DEF;
				nxt_s.fwd_member = '1;
				nxt_s.fwd_tag = '0;
				nxt_s.fwd_accept = 1'b1;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_ff <= '0;
		end else if (clk_en) begin
			s_ff <= nxt_s;
		end
	end

	assign prdata = s_ff.prdata;
	assign pready = s_ff.pready;
	assign pslverr = s_ff.pslverr;
	assign fwd_valid = s_ff.fwd_valid;
	assign fwd_accept = s_ff.fwd_accept;
	assign fwd_vid = s_ff.fwd_vid;
	assign fwd_member = s_ff.fwd_member;
	assign fwd_tag = s_ff.fwd_tag;

endmodule // vim_membership

// file: vim_pkg.sv
// register map, field positions, restart defaults, limits and mode codes of the vlan block
// assumes a 32-bit apb slave with byte addresses on an 8-bit address bus
package vim_pkg;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_ING_EN = 8'h08;
	localparam logic [7:0] OFF_TRUNK = 8'h0c;
	localparam logic [7:0] OFF_ENT_SEL = 8'h10;
	localparam logic [7:0] OFF_PB_VIEW = 8'h14;
	localparam logic [7:0] OFF_ENT_VID = 8'h20;
	localparam logic [7:0] OFF_ENT_EGR = 8'h24;
	localparam logic [7:0] OFF_ENT_FBD = 8'h28;
	localparam logic [7:0] OFF_ENT_TAG = 8'h2c;
	localparam logic [7:0] OFF_ENT_NAME = 8'h30;
	localparam logic [7:0] OFF_ENT_CMD = 8'h34;
	localparam logic [1:0] OFF_WIN_PDV = 2'h1;
	localparam logic [1:0] OFF_WIN_PB = 2'h2;
	localparam int CTRL_RESTART_BIT = 4;
	localparam int TRUNK_ANCHOR_LSB = 16;
	localparam int ENT_CMD_CLEAR_BIT = 0;
	localparam int PB_VIEW_OTHER_LSB = 16;
	localparam logic [1:0] MODE_DIS = 2'h0;
	localparam logic [1:0] MODE_MAC = 2'h1;
	localparam logic [1:0] MODE_PORT = 2'h2;
	localparam logic [1:0] MODE_TAG = 2'h3;
	localparam logic [11:0] VID_DEF = 12'h001;
	localparam logic [11:0] VID_MAX = 12'hffe;
	localparam logic [4:0] PB_VID_DEF = 5'h01;
	localparam logic [4:0] PB_VID_MAX = 5'h18;
endpackage

// file: vim_membership_props.sv
// port-level assertions of the vlan membership block
// assumes one pclk domain, async active-low presetn
`timescale 1ns/1ps
module vim_membership_props #(
	parameter int NP = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rx_valid,
	input wire logic fwd_valid,
	input wire logic fwd_accept,
	input wire logic [NP-1:0] fwd_member,
	input wire logic [NP-1:0] fwd_tag
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic wr_done;
	assign wr_done = psel && penable && pwrite && pready;
	chk_fwd_latency: assert property (rx_valid && clk_en |=> fwd_valid)
		else $error("no result after frame");
	chk_fwd_spurious: assert property (clk_en && !rx_valid |=> !fwd_valid)
		else $error("result without frame");
	chk_tag_members: assert property (fwd_valid |-> (fwd_tag & ~fwd_member) == '0)
		else $error("tag on non-member");
	chk_pb_range: assert property (wr_done && paddr[7:6] == 2'h2 && pwdata > 32'h18 |-> pslverr)
		else $error("port vlan above 24 taken");
	chk_pb_accept: assert property (wr_done && paddr[7:6] == 2'h2 && paddr[5:2] < NP
		&& pwdata <= 32'h18 |-> !pslverr)
		else $error("legal port vlan refused");
	chk_vid_range: assert property (wr_done && paddr == vim_pkg::OFF_ENT_VID
		&& pwdata > 32'hffe |-> pslverr)
		else $error("vid above 4094 taken");
	chk_apb_wait: assert property (psel && penable && !pready && clk_en |=> pready)
		else $error("ready late");
	chk_ready_pulse: assert property (pready && clk_en |=> !pready)
		else $error("ready held");
	chk_unmapped_err: assert property (psel && penable && pready && paddr == 8'h18 |-> pslverr)
		else $error("unmapped access accepted");
	chk_wr_rdata: assert property (wr_done |-> prdata == 32'h0)
		else $error("read data on write");
	cover property (fwd_valid && fwd_accept);
	cover property (fwd_valid && !fwd_accept);
	cover property (pready && pslverr);
endmodule // vim_membership_props
bind vim_membership vim_membership_props #(.NP(NP)) u_props (
	.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .rx_valid(rx_valid), .fwd_valid(fwd_valid), .fwd_accept(fwd_accept),
	.fwd_member(fwd_member), .fwd_tag(fwd_tag)
);

// file: vim_seg_model.sv
// attached segment stand-in: one frame descriptor per send call
// assumes send is entered just after a rising pclk edge
`timescale 1ns/1ps
module vim_seg_model #(
	parameter int PW = 3
) (
	input wire logic pclk,
	output logic rx_valid,
	output logic [PW-1:0] rx_port,
	output logic rx_tagged,
	output logic [11:0] rx_vid
);
	initial begin
		rx_valid = 1'h0;
		rx_port = '0;
		rx_tagged = 1'h0;
		rx_vid = 12'h0;
	end
	// fields inverted between frames
	task automatic send(input logic [PW-1:0] p, input logic t, input logic [11:0] v);
		rx_valid <= 1'h1;
		rx_port <= p;
		rx_tagged <= t;
		rx_vid <= v;
		@(posedge pclk);
		rx_valid <= 1'h0;
		rx_port <= ~p;
		rx_tagged <= ~t;
		rx_vid <= ~v;
	endtask
endmodule // vim_seg_model

// file: tb_vim_membership.sv
// self-checking bench of the vlan membership block
// assumes vim_pkg, the design, its checker and the segment model
`timescale 1ns/1ps
module tb_vim_membership;
	typedef struct packed {
		logic [1:0] k;
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] e;
	} vim_row_t;
	logic pclk = 1'h0;
	logic presetn, clk_en, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0] paddr, fwd_member, fwd_tag;
	logic [31:0] pwdata, prdata, rd;
	logic rx_valid, rx_tagged, fwd_valid, fwd_accept;
	logic [2:0] rx_port;
	logic [11:0] rx_vid, fwd_vid;
	int miscompares = 0;
	int n_checks = 0;
	vim_row_t rows [$];
	`define CHK(n, x, g) begin n_checks++; if ((g) !== (x)) begin miscompares++; \
		$display("[ERR] %s expected %h seen %h", n, x, g); end end
	always #2 pclk = ~pclk;
	vim_membership uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_port(rx_port),
		.rx_tagged(rx_tagged), .rx_vid(rx_vid), .fwd_valid(fwd_valid), .fwd_accept(fwd_accept),
		.fwd_vid(fwd_vid), .fwd_member(fwd_member), .fwd_tag(fwd_tag));
	vim_seg_model seg (.pclk(pclk), .rx_valid(rx_valid), .rx_port(rx_port),
		.rx_tagged(rx_tagged), .rx_vid(rx_vid));
	function automatic vim_row_t rw(logic [7:0] a, logic [31:0] d, logic e);
		return '{2'h0, a, d, {31'h0, e}};
	endfunction
	function automatic vim_row_t rr(logic [7:0] a, logic [31:0] e);
		return '{2'h1, a, 32'h0, e};
	endfunction
	function automatic vim_row_t rf(logic t, logic [2:0] p, logic [11:0] v, logic ac,
		logic [11:0] ev, logic [7:0] m, logic [7:0] g);
		return '{2'h3, {4'h0, t, p}, {20'h0, v}, {3'h0, ac, ev, m, g}};
	endfunction
	task automatic end_of_test();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n >= 50) begin
			miscompares++;
			end_of_test();
		end
		@(posedge pclk);
	endtask
	initial begin
		presetn = 1'h0;
		clk_en = 1'h1;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		`CHK("reset_fwd", 1'h0, fwd_valid)
		$display("reset test done");
		@(posedge pclk);
		rows = '{rr(8'h04, 32'h0), rf(1'h1, 3'h3, 12'h9, 1'h1, 12'h1, 8'hff, 8'h0),
			rw(8'h00, 32'h13, 1'h0), rr(8'h04, 32'hf), rr(8'h48, 32'h1),
			rr(8'h20, 32'h1), rr(8'h24, 32'hff), rw(8'h08, 32'h4, 1'h0),
			rw(8'h10, 32'h1, 1'h0), rw(8'h20, 32'h5, 1'h0), rw(8'h24, 32'hc, 1'h0),
			rw(8'h2c, 32'h8, 1'h0), rw(8'h28, 32'h10, 1'h0), rr(8'h24, 32'hc),
			rf(1'h1, 3'h2, 12'h5, 1'h1, 12'h5, 8'hc, 8'h8),
			rf(1'h0, 3'h2, 12'h5, 1'h0, 12'h1, 8'hff, 8'h0),
			rf(1'h1, 3'h2, 12'h7, 1'h0, 12'h7, 8'h0, 8'h0),
			rf(1'h1, 3'h5, 12'h7, 1'h1, 12'h7, 8'h0, 8'h0),
			rf(1'h1, 3'h4, 12'h5, 1'h1, 12'h5, 8'hc, 8'h8),
			rw(8'h44, 32'h5, 1'h0), rf(1'h0, 3'h1, 12'h0, 1'h1, 12'h5, 8'hc, 8'h8),
			rw(8'h20, 32'hfff, 1'h1), rw(8'h20, 32'hffe, 1'h0), rr(8'h20, 32'hffe),
			rw(8'h30, 32'h1234abcd, 1'h0), rw(8'h34, 32'h1, 1'h0), rr(8'h30, 32'h0),
			rr(8'h24, 32'h0), rr(8'h28, 32'h0), rr(8'h2c, 32'h8), '{2'h2, 8'h18, 32'h0, 32'h0},
			rw(8'h00, 32'h12, 1'h0), rr(8'h04, 32'ha), rw(8'h8c, 32'h7, 1'h0),
			rw(8'h94, 32'h7, 1'h0), rw(8'h14, 32'h1, 1'h0), rr(8'h14, 32'h2800d7),
			rw(8'h8c, 32'h0, 1'h0), rr(8'h8c, 32'h1), rw(8'h80, 32'h19, 1'h1),
			rw(8'h80, 32'h18, 1'h0), rr(8'h80, 32'h18),
			rf(1'h0, 3'h5, 12'h0, 1'h1, 12'h7, 8'h20, 8'h0),
			rw(8'h0c, 32'h50040, 1'h0), rw(8'h58, 32'h9, 1'h0), rw(8'h54, 32'h3, 1'h0),
			rr(8'h58, 32'h3), rw(8'h00, 32'h1, 1'h0), rr(8'h04, 32'h9)};
		foreach (rows[i]) begin
			if (rows[i].k == 2'h3) begin
				seg.send(rows[i].a[2:0], rows[i].a[3], rows[i].d[11:0]);
				@(posedge pclk);
				`CHK("frame", {1'h1, rows[i].e[28:0]}, {fwd_valid, fwd_accept, fwd_vid, fwd_member, fwd_tag})
			end else begin
				apb(rows[i].k == 2'h0, rows[i].a, rows[i].d);
				`CHK("pslverr", rows[i].k == 2'h0 ? rows[i].e[0] : rows[i].k == 2'h2, er)
				if (rows[i].k == 2'h1) `CHK("prdata", rows[i].e, rd)
			end
			$display("row %0d done", i);
		end
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		`CHK("reset_ready", 1'h0, pready)
		presetn <= 1'h1;
		@(posedge pclk);
		apb(1'h0, vim_pkg::OFF_STATUS, 32'h0);
		`CHK("reset_status", 32'h0, rd)
		clk_en <= 1'h0;
		seg.send(3'h0, 1'h1, 12'h5);
		@(posedge pclk);
		`CHK("frozen_fwd", 1'h0, fwd_valid)
		clk_en <= 1'h1;
		$display("second reset test done");
		end_of_test();
	end
endmodule // tb_vim_membership
